// ---- caf_pkg.sv ----
// Contract
// (R1) Software reads error counters only in sleep or init mode, request and ack.
// (R2) Error counter reads outside sleep or init mode return zero, not counts.
// (R3) Error counters are not writable except in test mode.
// (R4) Each message lands in background buffer; only accepted ones notify the CPU.
// (R5) Acceptance compares code registers with the four identifier bytes bit by bit.
// (R6) Extended identifiers use four register pairs; standard identifiers only the first two.
// (R7) Each code register holds an 8-bit pattern; first bank resets to zero.
// (R8) The code comparison is qualified by the matching mask register.
// (R9) Code and mask registers read anytime, write only in init mode.
// (R10) Mask bit zero requires code bit to equal identifier bit.
// (R11) Mask bit one makes the code bit a don't care.
// (R12) Accept only when every unmasked identifier bit equals its code bit.
// (R13) Software sets low three mask bits of masks 1 and 5 for standard ids.
// (R14) Code or mask writes outside init mode are ignored.
// (R15) Organisation field: 00 two 32-bit, 01 four 16-bit, 10 eight 8-bit, 11 closed.
// (R16) Closed organisation accepts nothing; foreground buffer never reloads.
// (R17) Hit index 0..7 names the filter of the foreground message, updated on load.
package caf_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] CAF_OFS_CTRL = 8'h00;
    localparam logic [7:0] CAF_OFS_STATUS = 8'h04;
    localparam logic [7:0] CAF_OFS_ERRCNT = 8'h08;
    localparam logic [7:0] CAF_OFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] CAF_OFS_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] CAF_OFS_IRQ_ENABLE = 8'h14;
    localparam logic [7:0] CAF_OFS_RX_ID = 8'h18;
    localparam logic [7:0] CAF_OFS_RX_RELEASE = 8'h1C;
    localparam logic [7:0] CAF_OFS_CODE0 = 8'h20;
    localparam logic [7:0] CAF_OFS_MASK0 = 8'h40;
    localparam logic [7:0] CAF_OFS_BANK_END = 8'h60;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CAF_CTRL_INIT_BIT = 0;
    localparam int CAF_CTRL_SLEEP_BIT = 1;
    localparam int CAF_CTRL_ORG_LSB = 4;
    localparam int CAF_ST_INIT_ACK_BIT = 0;
    localparam int CAF_ST_SLEEP_ACK_BIT = 1;
    localparam int CAF_ST_FG_FULL_BIT = 2;
    localparam int CAF_ST_HIT_LSB = 8;
    localparam int CAF_ERR_TX_LSB = 8;
    localparam int CAF_EV_ACCEPT_BIT = 0;
    localparam int CAF_EV_OVERRUN_BIT = 1;
    localparam int CAF_EV_W = 2;
    // ----------------------------------------
    // Reset values and responses
    // ----------------------------------------
    localparam logic [7:0] CAF_CODE_RST = 8'h00;
    localparam logic [7:0] CAF_MASK_RST = 8'h00;
    localparam logic [1:0] CAF_RESP_OKAY = 2'h0;
    localparam logic [1:0] CAF_RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        CAF_ORG_32 = 2'b00,
        CAF_ORG_16 = 2'b01,
        CAF_ORG_8 = 2'b10,
        CAF_ORG_CLOSED = 2'b11
    } caf_org_t;
endpackage

// ---- caf_filter.sv ----
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module caf_filter
    import caf_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int NUM_REGS = 8
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Protocol engine side
    output logic init_request,
    output logic sleep_request,
    input wire logic init_ack,
    input wire logic sleep_ack,
    input wire logic test_mode,
    input wire logic [7:0] rx_error_counter,
    input wire logic [7:0] tx_error_counter,
    output logic err_cnt_wr,
    output logic [7:0] err_cnt_wr_rx,
    output logic [7:0] err_cnt_wr_tx,
    input wire logic msg_valid,
    input wire logic [31:0] msg_id,
    input wire logic msg_ext,
    output logic rx_accept,
    output logic irq
);
    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    if (ADDR_W < 7 || ADDR_W > 8) begin : g_bad_addr
        $error("caf_filter: ADDR_W must be 7 or 8");
    end
    if (NUM_REGS != 8) begin : g_bad_regs
        $error("caf_filter: NUM_REGS must be 8");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic awv;
        logic [7:0] awaddr;
        logic wv;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bv;
        logic [1:0] bresp;
        logic rv;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic init_rq;
        logic sleep_rq;
        caf_org_t org;
        logic [7:0][7:0] code;
        logic [7:0][7:0] mask;
        logic bgv;
        logic [31:0] bg_id;
        logic bg_ext;
        logic fgv;
        logic [31:0] fg_id;
        logic [2:0] hit;
        logic accept;
        logic [CAF_EV_W-1:0] irq_st;
        logic [CAF_EV_W-1:0] irq_en;
        logic ewr;
        logic [7:0] ewr_rx;
        logic [7:0] ewr_tx;
    } caf_state_t;

    caf_state_t s_q;
    caf_state_t s_d;

    logic in_init;
    logic in_sleep;
    logic [7:0] m32;
    logic [7:0] m16;
    logic [7:0] m8;
    logic [7:0] acc;
    logic any_acc;
    logic [2:0] first_hit;
    logic do_wr;
    logic [7:0] wa;
    logic [7:0] ra;
    logic [CAF_EV_W-1:0] ev;
    logic [CAF_EV_W-1:0] clr;

    assign in_init = s_q.init_rq && init_ack;
    assign in_sleep = s_q.sleep_rq && sleep_ack;
    assign wa = 8'(s_axi_awaddr);
    assign ra = 8'(s_axi_araddr);

    // ----------------------------------------
    // Per-register byte comparison
    // ----------------------------------------
    // Each code register is compared against the identifier byte its slot
    // faces in every organisation; the organisation later picks which applies.
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_cmp
        localparam int B32 = i % 4;
        localparam int B16 = i % 2;
        logic [7:0] b32;
        logic [7:0] b16;
        logic [7:0] b8;
        assign b32 = s_q.bg_id[31-8*B32 -: 8];
        assign b16 = s_q.bg_id[31-8*B16 -: 8];
        assign b8 = s_q.bg_id[31:24];
        // Standard identifiers only use the first two pairs of a bank
        assign m32[i] = (B32 >= 2 && !s_q.bg_ext) ? 1'b1 :
            (((b32 ^ s_q.code[i]) & ~s_q.mask[i]) == 8'h00); // R5 R6 R8 R10 R11
        assign m16[i] = (((b16 ^ s_q.code[i]) & ~s_q.mask[i]) == 8'h00); // R5 R10 R11
        assign m8[i] = (((b8 ^ s_q.code[i]) & ~s_q.mask[i]) == 8'h00); // R5 R10 R11
    end

    // ----------------------------------------
    // Filter organisation and hit priority
    // ----------------------------------------
    always_comb begin
        acc = 8'h00;
        unique case (s_q.org) // R15
            CAF_ORG_32: begin
                for (int k = 0; k < 2; k++) begin
                    acc[k] = &m32[4*k +: 4]; // R12
                end
            end
            CAF_ORG_16: begin
                for (int k = 0; k < 4; k++) begin
                    acc[k] = m16[2*k] & m16[2*k+1]; // R12
                end
            end
            CAF_ORG_8: begin
                acc = m8; // R12
            end
            CAF_ORG_CLOSED: begin
                acc = 8'h00; // R16
            end
        endcase
        any_acc = |acc;
        first_hit = 3'h0;
        // Lowest numbered filter wins when several match
        for (int k = 7; k >= 0; k--) begin
            if (acc[k]) begin
                first_hit = 3'(k);
            end
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        ev = '0;
        clr = '0;
        do_wr = s_q.awv && s_q.wv && !s_q.bv;
        s_d.ewr = 1'b0;
        s_d.accept = 1'b0;

        // Write channel capture, either order
        if (s_axi_awvalid && !s_q.awv) begin
            s_d.awv = 1'b1;
            s_d.awaddr = wa;
        end
        if (s_axi_wvalid && !s_q.wv) begin
            s_d.wv = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (s_q.bv && s_axi_bready) begin
            s_d.bv = 1'b0;
        end

        if (do_wr) begin
            s_d.awv = 1'b0;
            s_d.wv = 1'b0;
            s_d.bv = 1'b1;
            s_d.bresp = CAF_RESP_OKAY;
            if (s_q.awaddr >= CAF_OFS_CODE0 && s_q.awaddr < CAF_OFS_BANK_END
                && s_q.awaddr[1:0] == 2'b00) begin
                // Filter bank changes only in init mode; otherwise dropped silently
                if (in_init && s_q.wstrb[0]) begin // R9 R14
                    if (s_q.awaddr < CAF_OFS_MASK0) begin
                        s_d.code[s_q.awaddr[4:2]] = s_q.wdata[7:0]; // R7
                    end else begin
                        s_d.mask[s_q.awaddr[4:2]] = s_q.wdata[7:0];
                    end
                end
            end else begin
                unique case (s_q.awaddr)
                    CAF_OFS_CTRL: begin
                        if (s_q.wstrb[0]) begin
                            s_d.init_rq = s_q.wdata[CAF_CTRL_INIT_BIT];
                            s_d.sleep_rq = s_q.wdata[CAF_CTRL_SLEEP_BIT];
                            if (in_init) begin // R9
                                s_d.org = caf_org_t'(s_q.wdata[CAF_CTRL_ORG_LSB +: 2]);
                            end
                        end
                    end
                    CAF_OFS_ERRCNT: begin
                        // Counters belong to the engine; only test mode may force them
                        if (test_mode) begin // R3
                            s_d.ewr = 1'b1;
                            s_d.ewr_rx = s_q.wdata[7:0];
                            s_d.ewr_tx = s_q.wdata[CAF_ERR_TX_LSB +: 8];
                        end
                    end
                    CAF_OFS_IRQ_CLEAR: begin
                        clr = s_q.wdata[CAF_EV_W-1:0];
                    end
                    CAF_OFS_IRQ_ENABLE: begin
                        s_d.irq_en = s_q.wdata[CAF_EV_W-1:0];
                    end
                    CAF_OFS_RX_RELEASE: begin
                        s_d.fgv = 1'b0;
                    end
                    CAF_OFS_STATUS, CAF_OFS_IRQ_STATUS, CAF_OFS_RX_ID: begin
                        s_d.bresp = CAF_RESP_OKAY;
                    end
                    default: begin
                        s_d.bresp = CAF_RESP_DECERR;
                    end
                endcase
            end
        end

        // Read channel
        if (s_q.rv && s_axi_rready) begin
            s_d.rv = 1'b0;
        end
        if (s_axi_arvalid && !s_q.rv) begin
            s_d.rv = 1'b1;
            s_d.rdata = 32'h0000_0000;
            s_d.rresp = CAF_RESP_OKAY;
            if (ra >= CAF_OFS_CODE0 && ra < CAF_OFS_BANK_END && ra[1:0] == 2'b00) begin
                s_d.rdata[7:0] = (ra < CAF_OFS_MASK0) ? s_q.code[ra[4:2]]
                                                      : s_q.mask[ra[4:2]]; // R9
            end else begin
                unique case (ra)
                    CAF_OFS_CTRL: begin
                        s_d.rdata[CAF_CTRL_INIT_BIT] = s_q.init_rq;
                        s_d.rdata[CAF_CTRL_SLEEP_BIT] = s_q.sleep_rq;
                        s_d.rdata[CAF_CTRL_ORG_LSB +: 2] = s_q.org;
                    end
                    CAF_OFS_STATUS: begin
                        s_d.rdata[CAF_ST_INIT_ACK_BIT] = init_ack;
                        s_d.rdata[CAF_ST_SLEEP_ACK_BIT] = sleep_ack;
                        s_d.rdata[CAF_ST_FG_FULL_BIT] = s_q.fgv;
                        s_d.rdata[CAF_ST_HIT_LSB +: 3] = s_q.hit; // R17
                    end
                    CAF_OFS_ERRCNT: begin
                        // Counts are only coherent while the engine is parked
                        if (in_init || in_sleep) begin // R1 R2
                            s_d.rdata[7:0] = rx_error_counter;
                            s_d.rdata[CAF_ERR_TX_LSB +: 8] = tx_error_counter;
                        end
                    end
                    CAF_OFS_IRQ_STATUS: begin
                        s_d.rdata[CAF_EV_W-1:0] = s_q.irq_st;
                    end
                    CAF_OFS_IRQ_ENABLE: begin
                        s_d.rdata[CAF_EV_W-1:0] = s_q.irq_en;
                    end
                    CAF_OFS_RX_ID: begin
                        s_d.rdata = s_q.fg_id;
                    end
                    CAF_OFS_IRQ_CLEAR, CAF_OFS_RX_RELEASE: begin
                        s_d.rdata = 32'h0000_0000;
                    end
                    default: begin
                        s_d.rresp = CAF_RESP_DECERR;
                    end
                endcase
            end
        end

        // ----------------------------------------
        // Receive path
        // ----------------------------------------
        // Background evaluates one cycle after capture and its valid bit is then
        // cleared unless a new message arrives, which is how rejected frames are dropped.
        s_d.bgv = 1'b0;
        if (s_q.bgv && any_acc) begin // R4
            if (!s_q.fgv || (do_wr && s_q.awaddr == CAF_OFS_RX_RELEASE)) begin
                s_d.fgv = 1'b1;
                s_d.fg_id = s_q.bg_id;
                s_d.hit = first_hit; // R17
                s_d.accept = 1'b1;
                ev[CAF_EV_ACCEPT_BIT] = 1'b1;
            end else begin
                ev[CAF_EV_OVERRUN_BIT] = 1'b1;
            end
        end
        if (msg_valid) begin
            s_d.bgv = 1'b1; // R4
            s_d.bg_id = msg_id;
            s_d.bg_ext = msg_ext;
        end

        // Event set wins over a clear in the same cycle
        s_d.irq_st = (s_q.irq_st & ~clr) | ev;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.org <= CAF_ORG_32;
            for (int i = 0; i < NUM_REGS; i++) begin
                s_q.code[i] <= CAF_CODE_RST; // R7
                s_q.mask[i] <= CAF_MASK_RST;
            end
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign s_axi_awready = !s_q.awv;
    assign s_axi_wready = !s_q.wv;
    assign s_axi_bvalid = s_q.bv;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rv;
    assign s_axi_rvalid = s_q.rv;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign init_request = s_q.init_rq;
    assign sleep_request = s_q.sleep_rq;
    assign err_cnt_wr = s_q.ewr;
    assign err_cnt_wr_rx = s_q.ewr_rx;
    assign err_cnt_wr_tx = s_q.ewr_tx;
    assign rx_accept = s_q.accept;
    assign irq = |(s_q.irq_st & s_q.irq_en);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    bank_write_lock_a: assert property ( // R9
        !in_init |=> $stable(s_q.code) && $stable(s_q.mask))
        else $error("filter bank changed outside init mode");
    ignored_write_a: assert property ( // R14
        do_wr && !in_init && s_q.awaddr >= CAF_OFS_CODE0
        |=> $stable(s_q.code) && $stable(s_q.mask))
        else $error("filter bank written outside init mode");
    err_read_gate_a: assert property ( // R2
        s_axi_arvalid && !s_q.rv && ra == CAF_OFS_ERRCNT && !in_init && !in_sleep
        |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
        else $error("error counter leaked outside parked modes");
    err_read_value_a: assert property ( // R1
        s_axi_arvalid && !s_q.rv && ra == CAF_OFS_ERRCNT && in_init
        |=> s_axi_rdata[7:0] == $past(rx_error_counter))
        else $error("error counter read wrong in init mode");
    err_write_test_a: assert property ( // R3
        err_cnt_wr |-> $past(test_mode))
        else $error("error counter forced outside test mode");
    closed_no_load_a: assert property ( // R16
        s_q.org == CAF_ORG_CLOSED |=> !rx_accept)
        else $error("closed filter accepted a message");
    accept_source_a: assert property ( // R4
        rx_accept |-> $past(s_q.bgv) && $past(any_acc))
        else $error("accept without a matching message");
    hit_update_a: assert property ( // R17
        s_q.bgv && any_acc && !s_q.fgv |=> s_q.hit == $past(first_hit) && s_q.fgv)
        else $error("hit index not loaded with foreground");
    mask_match_a: assert property ( // R12
        s_q.org == CAF_ORG_8 && s_q.bgv && any_acc
        |-> ((s_q.bg_id[31:24] ^ s_q.code[first_hit]) & ~s_q.mask[first_hit]) == 8'h00)
        else $error("accepted byte differs in unmasked bits");
    accept_load_a: assert property ( // R4
        rx_accept |-> s_q.fgv && s_q.irq_st[CAF_EV_ACCEPT_BIT]
        && s_q.fg_id == $past(s_q.bg_id))
        else $error("accepted message not loaded into foreground");
endmodule

// ---- caf_engine_model.sv ----
`timescale 1ns/1ps
module caf_engine_model
    import caf_pkg::*;
#(
    parameter logic [7:0] RX_ERR_INIT = 8'h05,
    parameter logic [7:0] TX_ERR_INIT = 8'h0A
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic init_request,
    input wire logic sleep_request,
    output logic init_ack,
    output logic sleep_ack,
    output logic [7:0] rx_error_counter,
    output logic [7:0] tx_error_counter,
    input wire logic err_cnt_wr,
    input wire logic [7:0] err_cnt_wr_rx,
    input wire logic [7:0] err_cnt_wr_tx,
    output logic msg_valid,
    output logic [31:0] msg_id,
    output logic msg_ext
);
    initial begin
        msg_valid = 1'h0;
        msg_id = 32'h0;
        msg_ext = 1'h0;
    end
    // ----------------------------------------
    // Mode handshake and error counters
    // ----------------------------------------
    // Acks trail requests by a cycle, so software must wait for them
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            init_ack <= 1'h0;
            sleep_ack <= 1'h0;
            rx_error_counter <= RX_ERR_INIT;
            tx_error_counter <= TX_ERR_INIT;
        end else begin
            init_ack <= init_request;
            sleep_ack <= sleep_request;
            if (err_cnt_wr) begin
                rx_error_counter <= err_cnt_wr_rx;
                tx_error_counter <= err_cnt_wr_tx;
            end
        end
    end
    // ----------------------------------------
    // Message delivery
    // ----------------------------------------
    // Lines go to the inverse once the pulse is over, so stale ids never match
    task automatic send(input logic [31:0] id, input logic ext);
        @(posedge ref_clk);
        msg_valid <= 1'h1;
        msg_id <= id;
        msg_ext <= ext;
        @(posedge ref_clk);
        msg_valid <= 1'h0;
        msg_id <= ~id;
        msg_ext <= ~ext;
    endtask
endmodule

// ---- caf_filter_tb.sv ----
`timescale 1ns/1ps
module caf_filter_tb;
    import caf_pkg::*;
    logic ref_clk = 1'h0;
    logic rst_b = 1'h0;
    logic [7:0] awaddr = 8'h0;
    logic [7:0] araddr = 8'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic test_mode = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, init_request, sleep_request;
    logic init_ack, sleep_ack, err_cnt_wr, msg_valid, msg_ext, rx_accept, irq;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, msg_id, rd_v;
    logic [7:0] rx_err, tx_err, wr_rx, wr_tx;
    int err_total = 0, num_checks = 0, acc_cnt = 0;

    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (rx_accept === 1'h1) acc_cnt <= acc_cnt + 1;

    caf_filter u_caf_filter (.ref_clk(ref_clk), .rst_b(rst_b),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .init_request(init_request), .sleep_request(sleep_request), .init_ack(init_ack),
        .sleep_ack(sleep_ack), .test_mode(test_mode), .rx_error_counter(rx_err),
        .tx_error_counter(tx_err), .err_cnt_wr(err_cnt_wr), .err_cnt_wr_rx(wr_rx),
        .err_cnt_wr_tx(wr_tx), .msg_valid(msg_valid), .msg_id(msg_id), .msg_ext(msg_ext),
        .rx_accept(rx_accept), .irq(irq));

    caf_engine_model u_caf_engine_model (.ref_clk(ref_clk), .rst_b(rst_b),
        .init_request(init_request), .sleep_request(sleep_request), .init_ack(init_ack),
        .sleep_ack(sleep_ack), .rx_error_counter(rx_err), .tx_error_counter(tx_err),
        .err_cnt_wr(err_cnt_wr), .err_cnt_wr_rx(wr_rx), .err_cnt_wr_tx(wr_tx),
        .msg_valid(msg_valid), .msg_id(msg_id), .msg_ext(msg_ext));

    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        logic aw_ok = 1'h0, w_ok = 1'h0, done = 1'h0;
        @(posedge ref_clk);
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!done && n < 100) begin
            @(posedge ref_clk);
            n++;
            if (aw_ok && w_ok && bvalid) begin
                done = 1'h1;
                rsp = bresp;
                bready <= 1'h0;
            end
            if (awvalid && awready) begin
                aw_ok = 1'h1;
                awvalid <= 1'h0;
            end
            if (wvalid && wready) begin
                w_ok = 1'h1;
                wvalid <= 1'h0;
            end
        end
        if (!done) err_total++;
    endtask

    task automatic rd(input logic [7:0] a);
        int n = 0;
        logic ar_ok = 1'h0, done = 1'h0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!done && n < 100) begin
            @(posedge ref_clk);
            n++;
            if (ar_ok && rvalid) begin
                done = 1'h1;
                rd_v = rdata;
                rsp = rresp;
                rready <= 1'h0;
            end
            if (arvalid && arready) begin
                ar_ok = 1'h1;
                arvalid <= 1'h0;
            end
        end
        if (!done) err_total++;
    endtask

    task automatic chkrd(input string name, input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(name, rd_v, exp);
    endtask

    // Ack comes a cycle after the request, so give it time before relying on the mode
    task automatic mode(input logic [31:0] ctrl);
        wr(CAF_OFS_CTRL, ctrl);
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic cfg(input logic [1:0] org, input logic [63:0] codes, input logic [63:0] masks);
        mode(32'h1);
        mode({26'h0, org, 4'h1});
        for (int k = 0; k < 8; k++) begin
            wr(CAF_OFS_CODE0 + 8'(4 * k), {24'h0, codes[63 - 8 * k -: 8]});
            wr(CAF_OFS_MASK0 + 8'(4 * k), {24'h0, masks[63 - 8 * k -: 8]});
        end
        mode({26'h0, org, 4'h0});
    endtask

    task automatic msg(input logic [31:0] id, input logic ext, input logic acc,
                       input logic [2:0] hit);
        int a0;
        a0 = acc_cnt;
        u_caf_engine_model.send(id, ext);
        repeat (4) @(posedge ref_clk);
        chk("accept count", 32'(acc_cnt - a0), {31'h0, acc});
        if (acc) begin
            rd(CAF_OFS_STATUS);
            chk("hit index", {29'h0, rd_v[10:8]}, {29'h0, hit});
            chkrd("fg id", CAF_OFS_RX_ID, id);
            wr(CAF_OFS_RX_RELEASE, 32'h0);
            wr(CAF_OFS_IRQ_CLEAR, 32'h3);
        end
    endtask

    task automatic give_verdict;
        $display("Checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'h1;
        for (int k = 0; k < 8; k++) begin
            chkrd("code reset", CAF_OFS_CODE0 + 8'(4 * k), 32'h0);
            chkrd("mask reset", CAF_OFS_MASK0 + 8'(4 * k), 32'h0);
        end
        wr(CAF_OFS_CODE0, 32'h5A);
        chkrd("code locked", CAF_OFS_CODE0, 32'h0);
        chkrd("errcnt normal", CAF_OFS_ERRCNT, 32'h0);
        mode(32'h2);
        chkrd("errcnt sleep", CAF_OFS_ERRCNT, 32'h0A05);
        mode(32'h1);
        wr(CAF_OFS_CODE0, 32'h5A);
        chkrd("code in init", CAF_OFS_CODE0, 32'h5A);
        wr(CAF_OFS_ERRCNT, 32'h3344);
        chkrd("errcnt no test", CAF_OFS_ERRCNT, 32'h0A05);
        test_mode <= 1'h1;
        wr(CAF_OFS_ERRCNT, 32'h3344);
        test_mode <= 1'h0;
        chkrd("errcnt test", CAF_OFS_ERRCNT, 32'h3344);
        rd(CAF_OFS_BANK_END);
        chk("unmapped resp", {30'h0, rsp}, {30'h0, CAF_RESP_DECERR});
        wr(CAF_OFS_BANK_END, 32'h0);
        chk("unmapped wresp", {30'h0, rsp}, {30'h0, CAF_RESP_DECERR});
        // Masks 1 and 5 low bits opened so standard ids can match
        cfg(CAF_ORG_32, 64'h12345678_AABBCCDD, 64'h00070000_00070000);
        msg(32'h12345678, 1'h1, 1'h1, 3'h0);
        msg(32'h12345679, 1'h1, 1'h0, 3'h0);
        msg(32'hAABC1234, 1'h0, 1'h1, 3'h1);
        msg(32'hAABC1234, 1'h1, 1'h0, 3'h0);
        cfg(CAF_ORG_16, 64'h11223344_55667788, 64'h00070000_00070000);
        msg(32'h7788FFFF, 1'h1, 1'h1, 3'h3);
        msg(32'h33440000, 1'h0, 1'h1, 3'h1);
        cfg(CAF_ORG_8, 64'h10111213_14151617, 64'h0);
        msg(32'h17FFFFFF, 1'h1, 1'h1, 3'h7);
        msg(32'h15000000, 1'h0, 1'h1, 3'h5);
        cfg(CAF_ORG_CLOSED, 64'h0, 64'hFFFFFFFF_FFFFFFFF);
        msg(32'h00000000, 1'h1, 1'h0, 3'h0);
        cfg(CAF_ORG_8, 64'h0, 64'hFFFFFFFF_FFFFFFFF);
        wr(CAF_OFS_IRQ_ENABLE, 32'h1);
        u_caf_engine_model.send(32'h01020304, 1'h1);
        u_caf_engine_model.send(32'h05060708, 1'h1);
        repeat (4) @(posedge ref_clk);
        chk("irq raised", {31'h0, irq}, 32'h1);
        chkrd("irq status", CAF_OFS_IRQ_STATUS, 32'h3);
        chkrd("fg kept", CAF_OFS_RX_ID, 32'h01020304);
        chkrd("status", CAF_OFS_STATUS, 32'h4);
        wr(CAF_OFS_IRQ_ENABLE, 32'h0);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(CAF_OFS_IRQ_CLEAR, 32'h3);
        wr(CAF_OFS_IRQ_ENABLE, 32'h3);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        chkrd("irq status clr", CAF_OFS_IRQ_STATUS, 32'h0);
        chkrd("ctrl org", CAF_OFS_CTRL, 32'h20);
        chkrd("irq enable", CAF_OFS_IRQ_ENABLE, 32'h3);
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        give_verdict();
    end
endmodule
